// ===== src/bldbs_fifo.sv
// Request FIFO with registered flags, parameterised width and depth
`timescale 1ns/100ps
module bldbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, low
  input wire logic in_valid, // Writer has a word
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Reader takes word
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d, vld_q, vld_d, push, pop;

  // Pointer and count update; flags are registered from next count
  always_comb begin
    push = in_valid && rdy_q;
    pop = out_ready && vld_q;
    wp_d = push ? PW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? PW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    rdy_d = cnt_d != (PW+1)'(DEPTH);
    vld_d = cnt_d != '0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      vld_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
    end
  end

  // Storage needs no reset; only flagged words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  assign in_ready = rdy_q;
  assign out_valid = vld_q;
  assign out_data = mem[rp_q];
endmodule // bldbs_fifo

// ===== src/bldbs_pkg.sv
// Constants and types for the byte lane and dynamic bus sizing sequencer
//------------------------------------------------------------------
//------------------------------------------------------------------
package bldbs_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  // Request word: fill, io, write, length, address, write data
  localparam int REQ_W = 70;
  // Word address mask that keeps I/O cycles inside 64 KB
  localparam logic [29:0] IO_WORD_MASK = 30'h00003FFF;
  // Bus width codes taken from the width requests
  localparam logic [1:0] WID_32 = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_8 = 2'h2;
  // Lane masks, active high inside the block
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [7:0] FILL_LANES = 8'h0F;
  localparam logic [1:0] FILL_LAST = 2'h3;
  // Values after reset
  localparam logic [3:0] RST_SEL_N = 4'hF;
  localparam logic [29:0] RST_WORD = 30'h00000000;
  localparam logic [31:0] RST_DATA = 32'h00000000;
  localparam logic [63:0] RST_BUF = 64'h0000000000000000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT = 3'b100
  } bldbs_state_t;
endpackage

// ===== src/bldbs_top.sv
// Byte lane select generation and dynamic bus sizing sequencer
`timescale 1ns/100ps
module bldbs_top (
  input wire logic CLK_SYS, // 100 MHz clock
  input wire logic ARST_N, // Async reset, low
  input wire logic REQ_VALID, // Transfer request
  output logic REQ_READY, // Request FIFO has room
  input wire logic [bldbs_pkg::ADDR_W-1:0] REQ_ADDR, // Byte address
  input wire logic [2:0] REQ_LEN, // Bytes: 1, 2 or 4
  input wire logic REQ_WRITE, // 1 write, 0 read
  input wire logic REQ_IO, // 1 I/O space, 0 memory
  input wire logic REQ_FILL, // Line fill of 16 bytes
  input wire logic [bldbs_pkg::DATA_W-1:0] REQ_WDATA, // Operand
  output logic RSP_VALID, // One-cycle completion pulse
  output logic RSP_LAST, // Final pulse of a request
  output logic [bldbs_pkg::DATA_W-1:0] RSP_RDATA, // Read operand
  output logic BUSY, // Sequencer working
  output logic BUS_START, // One-cycle cycle start
  output logic [29:0] BUS_WORD_ADDR, // Word address
  output logic [3:0] BYTE_LANE_SEL_N, // Byte lane selects, low
  output logic BUS_MEM, // 1 memory, 0 I/O cycle
  output logic BUS_WRITE, // 1 write cycle
  input wire logic BUS_READY_N, // Cycle end, low
  input wire logic HALF_WIDTH_REQ_N, // 16-bit device, low
  input wire logic BYTE_WIDTH_REQ_N, // 8-bit device, low
  input wire logic [31:0] DATA_LANES_I, // Data lanes in
  output logic [31:0] DATA_LANES_O, // Data lanes out
  output logic DATA_LANES_OE_N // Lane drive enable, low
);
  import bldbs_pkg::*;

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------
  // Width from the two requests; both asserted counts as bytes
  function automatic logic [1:0] width_of(input logic half_n,
                                          input logic byte_n);
    if (!byte_n) begin
      width_of = WID_8;
    end else if (!half_n) begin
      width_of = WID_16;
    end else begin
      width_of = WID_32;
    end
  endfunction

  // Selects still needed after a cycle of the given width
  function automatic logic [3:0] next_sel(input logic [3:0] cur,
                                          input logic [1:0] w);
    case (w)
      WID_8: next_sel = cur & 4'(cur - 4'h1);
      WID_16: begin
        if ((|cur[1:0]) && (|cur[3:2])) begin
          next_sel = {cur[3:2], 2'b00};
        end else begin
          next_sel = LANES_NONE;
        end
      end
      default: next_sel = LANES_NONE;
    endcase
  endfunction

  // Lanes that carry valid read data for the given width
  function automatic logic [3:0] cap_sel(input logic [3:0] cur,
                                         input logic [1:0] w);
    case (w)
      WID_8: cap_sel = cur & ~4'(cur - 4'h1);
      WID_16: cap_sel = (|cur[1:0]) ? {2'b00, cur[1:0]} : cur;
      default: cap_sel = cur;
    endcase
  endfunction

  // Byte lane mask widened to a bit mask
  function automatic logic [31:0] lane_bits(input logic [3:0] m);
    lane_bits = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  //----------------------------------------------------------------
  // Request buffering
  //----------------------------------------------------------------
  logic fifo_rdy, head_vld, head_take;
  logic [REQ_W-1:0] head;

  bldbs_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .in_valid(REQ_VALID),
    .in_ready(fifo_rdy),
    .in_data({REQ_FILL, REQ_IO, REQ_WRITE, REQ_LEN, REQ_ADDR,
              REQ_WDATA}),
    .out_valid(head_vld),
    .out_ready(head_take),
    .out_data(head)
  );

  //----------------------------------------------------------------
  // Sequencer state
  //----------------------------------------------------------------
  bldbs_state_t st_q, st_d;
  logic [31:0] addr_q, addr_d;
  logic wr_q, wr_d, io_q, io_d, fill_q, fill_d, hi_q, hi_d;
  logic [1:0] fcnt_q, fcnt_d;
  logic [7:0] m8_q, m8_d;
  logic [63:0] wbuf_q, wbuf_d, rbuf_q, rbuf_d;
  logic start_q, start_d, mem_q, mem_d, bwr_q, bwr_d;
  logic [29:0] word_q, word_d;
  logic [3:0] sel_n_q, sel_n_d;
  logic [31:0] dout_q, dout_d, rsp_q, rsp_d;
  logic oe_n_q, oe_n_d, rv_q, rv_d, rl_q, rl_d, busy_q, busy_d;

  // Working values shared by the sequencer
  logic [3:0] cur, nxt, cap;
  logic [1:0] wid;
  logic [7:0] mask_new;
  logic [63:0] rbuf_new;
  logic [29:0] word_base;
  logic [31:0] word_wdata;
  logic [2:0] h_len;
  logic [31:0] h_addr;

  // Next state: issue one cycle, wait for its end, then either
  // narrow the selects, move to the other word, start the next fill word, or finish
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wr_d = wr_q;
    io_d = io_q;
    fill_d = fill_q;
    hi_d = hi_q;
    fcnt_d = fcnt_q;
    m8_d = m8_q;
    wbuf_d = wbuf_q;
    rbuf_d = rbuf_q;
    start_d = 1'b0;
    mem_d = mem_q;
    bwr_d = bwr_q;
    word_d = word_q;
    sel_n_d = sel_n_q;
    dout_d = dout_q;
    rsp_d = rsp_q;
    oe_n_d = oe_n_q;
    rv_d = 1'b0;
    rl_d = 1'b0;
    busy_d = busy_q;
    head_take = 1'b0;
    h_len = head[66:64];
    h_addr = head[63:32];
    mask_new = 8'h00;
    cur = hi_q ? m8_q[7:4] : m8_q[3:0];
    wid = width_of(HALF_WIDTH_REQ_N, BYTE_WIDTH_REQ_N);
    nxt = next_sel(cur, wid);
    cap = cap_sel(cur, wid);
    rbuf_new = rbuf_q;
    // Data is taken from the lanes the selects name, no shifting
    if (hi_q) begin
      rbuf_new[63:32] = (rbuf_q[63:32] & ~lane_bits(cap))
                        | (DATA_LANES_I & lane_bits(cap));
    end else begin
      rbuf_new[31:0] = (rbuf_q[31:0] & ~lane_bits(cap))
                       | (DATA_LANES_I & lane_bits(cap));
    end
    // Same word across the extra cycles of one aligned area
    word_base = fill_q ? {addr_q[31:4], fcnt_q}
                       : 30'(addr_q[31:2] + 30'(hi_q));
    if (io_q) begin
      word_base = word_base & IO_WORD_MASK;
    end
    word_wdata = hi_q ? wbuf_q[63:32] : wbuf_q[31:0];
    case (st_q)
      ST_IDLE: begin
        busy_d = head_vld;
        if (head_vld) begin
          head_take = 1'b1;
          fill_d = head[69];
          io_d = head[68] && !head[69];
          wr_d = head[67] && !head[69];
          addr_d = head[69] ? {h_addr[31:4], 4'h0} : h_addr;
          // Operand lanes over two words; upper byte half is word+1
          case (h_len)
            3'h1: mask_new = 8'h01;
            3'h2: mask_new = 8'h03;
            default: mask_new = 8'h0F;
          endcase
          mask_new = 8'(mask_new << h_addr[1:0]);
          if (head[69]) begin
            mask_new = FILL_LANES;
          end
          m8_d = mask_new;
          hi_d = |mask_new[7:4];
          fcnt_d = 2'h0;
          wbuf_d = 64'({32'h0, head[31:0]} << {h_addr[1:0], 3'b000});
          rbuf_d = RST_BUF;
          st_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        start_d = 1'b1;
        word_d = word_base;
        sel_n_d = ~cur;
        mem_d = !io_q;
        bwr_d = wr_q;
        oe_n_d = !wr_q;
        dout_d = word_wdata & lane_bits(cur);
        st_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (!BUS_READY_N) begin
          rbuf_d = rbuf_new;
          if (nxt != LANES_NONE) begin
            // Extra cycle on the same word with fewer selects
            if (hi_q) begin
              m8_d[7:4] = nxt;
            end else begin
              m8_d[3:0] = nxt;
            end
            st_d = ST_ISSUE;
          end else if (hi_q && (m8_q[3:0] != LANES_NONE)) begin
            // Upper word done; lower-order bytes follow
            m8_d[7:4] = LANES_NONE;
            hi_d = 1'b0;
            st_d = ST_ISSUE;
          end else if (fill_q && (fcnt_q != FILL_LAST)) begin
            // Hand each filled word up, then start the next
            rv_d = 1'b1;
            rsp_d = rbuf_new[31:0];
            fcnt_d = 2'(fcnt_q + 2'h1);
            m8_d = FILL_LANES;
            rbuf_d = RST_BUF;
            st_d = ST_ISSUE;
          end else begin
            rv_d = 1'b1;
            rl_d = 1'b1;
            rsp_d = 32'(rbuf_new >> {addr_q[1:0], 3'b000});
            m8_d = 8'h00;
            sel_n_d = RST_SEL_N;
            oe_n_d = 1'b1;
            busy_d = 1'b0;
            st_d = ST_IDLE;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer and output registers
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= ST_IDLE;
      addr_q <= RST_DATA;
      wr_q <= 1'b0;
      io_q <= 1'b0;
      fill_q <= 1'b0;
      hi_q <= 1'b0;
      fcnt_q <= 2'h0;
      m8_q <= 8'h00;
      wbuf_q <= RST_BUF;
      rbuf_q <= RST_BUF;
      start_q <= 1'b0;
      mem_q <= 1'b1;
      bwr_q <= 1'b0;
      word_q <= RST_WORD;
      sel_n_q <= RST_SEL_N;
      dout_q <= RST_DATA;
      rsp_q <= RST_DATA;
      oe_n_q <= 1'b1;
      rv_q <= 1'b0;
      rl_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      io_q <= io_d;
      fill_q <= fill_d;
      hi_q <= hi_d;
      fcnt_q <= fcnt_d;
      m8_q <= m8_d;
      wbuf_q <= wbuf_d;
      rbuf_q <= rbuf_d;
      start_q <= start_d;
      mem_q <= mem_d;
      bwr_q <= bwr_d;
      word_q <= word_d;
      sel_n_q <= sel_n_d;
      dout_q <= dout_d;
      rsp_q <= rsp_d;
      oe_n_q <= oe_n_d;
      rv_q <= rv_d;
      rl_q <= rl_d;
      busy_q <= busy_d;
    end
  end

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  // Everything leaves from a flop; FIFO ready is its own flop
  assign REQ_READY = fifo_rdy;
  assign RSP_VALID = rv_q;
  assign RSP_LAST = rl_q;
  assign RSP_RDATA = rsp_q;
  assign BUSY = busy_q;
  assign BUS_START = start_q;
  assign BUS_WORD_ADDR = word_q;
  assign BYTE_LANE_SEL_N = sel_n_q;
  assign BUS_MEM = mem_q;
  assign BUS_WRITE = bwr_q;
  assign DATA_LANES_O = dout_q;
  assign DATA_LANES_OE_N = oe_n_q;
endmodule // bldbs_top

// ===== test/bldbs_bench.sv
// Self-checking bench for the bus sizing sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("Error %0t: got %0h want %0h", $time, (a), (e)); \
  end \
end
module bldbs_bench;
  import bldbs_pkg::*;
  logic clk, arst_n, req_valid, req_ready, req_write, req_io, req_fill;
  logic rsp_valid, rsp_last, bus_start, bus_mem, bus_write, ready_n;
  logic half_n, byte_n, oe_n, busy, f_busy, f_mem;
  logic [2:0] req_len;
  logic [1:0] wid;
  logic [4:0] dly;
  logic [3:0] sel_n, f_sel;
  logic [29:0] word_addr, f_word;
  logic [31:0] req_addr, req_wdata, rsp_rdata, lanes_i, lanes_o, f_do;
  int bad_count, n_compared, cyc, starts, rsps;
  bldbs_top dut (.CLK_SYS(clk), .ARST_N(arst_n), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_ADDR(req_addr), .REQ_LEN(req_len),
    .REQ_WRITE(req_write), .REQ_IO(req_io), .REQ_FILL(req_fill),
    .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_LAST(rsp_last),
    .RSP_RDATA(rsp_rdata), .BUSY(busy), .BUS_START(bus_start),
    .BUS_WORD_ADDR(word_addr), .BYTE_LANE_SEL_N(sel_n), .BUS_MEM(bus_mem),
    .BUS_WRITE(bus_write), .BUS_READY_N(ready_n),
    .HALF_WIDTH_REQ_N(half_n), .BYTE_WIDTH_REQ_N(byte_n),
    .DATA_LANES_I(lanes_i), .DATA_LANES_O(lanes_o), .DATA_LANES_OE_N(oe_n));
  bldbs_dev far (.clk(clk), .arst_n(arst_n), .bus_start(bus_start),
    .word_addr(word_addr), .sel_n(sel_n), .wid(wid), .dly(dly),
    .ready_n(ready_n), .half_n(half_n), .byte_n(byte_n), .lanes(lanes_i));
  //----------------------------------------------------------------
  // Helpers and scenarios
  //----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hang is cut short well beyond the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] exp_rd(input logic [31:0] a, input int n);
    exp_rd = 32'h0;
    for (int k = 0; k < n; k++) exp_rd[8*k +: 8] = 8'(a + k) ^ 8'hA5;
  endfunction
  // Push one request, then watch the bus until its last response
  task automatic run(input logic [31:0] a, input logic [2:0] len,
                     input logic wr, io, fill);
    logic ok;
    req_addr = a;
    req_len = len;
    req_write = wr;
    req_io = io;
    req_fill = fill;
    req_valid = 1'b1;
    ok = 1'b0;
    while (!ok) begin
      ok = req_ready;
      @(negedge clk);
    end
    req_valid = 1'b0;
    starts = 0;
    rsps = 0;
    for (int n = 0; n < 600; n++) begin
      @(negedge clk);
      if (bus_start === 1'b1) begin
        if (starts == 0) begin
          f_sel = sel_n;
          f_word = word_addr;
          f_do = lanes_o;
          f_busy = busy;
          f_mem = bus_mem;
        end
        starts++;
      end
      if (rsp_valid === 1'b1) rsps++;
      if (rsp_last === 1'b1) break;
    end
  endtask
  task automatic cs(input logic [31:0] a, input logic [2:0] len,
    input logic wr, io, fill, input logic [1:0] w, input int ns,
    input logic [3:0] s, input logic [29:0] wa);
    int n;
    n = fill ? 4 : int'(len);
    wid = w;
    run(a, len, wr, io, fill);
    `CHK(starts, ns)
    `CHK(rsps, fill ? 4 : 1)
    `CHK(f_sel, s)
    `CHK(f_word, wa)
    if (!wr) `CHK(rsp_rdata & (32'hFFFFFFFF >> (32 - 8 * n)),
      exp_rd(fill ? {a[31:4], 4'hC} : a, n))
    if (wr) `CHK(f_do, (req_wdata & (32'hFFFFFFFF >> (32 - 8 * n)))
      << (8 * a[1:0]))
    `CHK(f_mem, !io)
    `CHK(f_busy, 1'b1)
    `CHK(busy, 1'b0)
  endtask
  // Far side stalls so the queue fills until it refuses, then drains
  task automatic t_fifo;
    int pushed, got;
    pushed = 0;
    got = 0;
    dly = 5'd15;
    req_valid = 1'b1;
    for (int i = 0; i < 12; i++) begin
      if (req_ready === 1'b1) pushed++;
      @(negedge clk);
    end
    req_valid = 1'b0;
    `CHK(pushed, 9)
    for (int i = 0; i < 1000 && got < pushed; i++) begin
      @(negedge clk);
      if (rsp_last === 1'b1) got++;
    end
    `CHK(got, 9)
    dly = 5'd0;
  endtask
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_addr = 32'h0;
    req_len = 3'h4;
    req_write = 1'b0;
    req_io = 1'b0;
    req_fill = 1'b0;
    req_wdata = 32'hC0DEBEEF;
    wid = 2'h0;
    dly = 5'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    cs(32'h1230, 4, 0, 0, 0, 0, 1, 4'h0, 30'h48C);
    cs(32'h1230, 4, 0, 0, 0, 1, 2, 4'h0, 30'h48C);
    cs(32'h1230, 4, 0, 0, 0, 2, 4, 4'h0, 30'h48C);
    cs(32'h1230, 4, 0, 0, 0, 3, 4, 4'h0, 30'h48C);
    dly = 5'h2;
    cs(32'h1231, 4, 0, 0, 0, 0, 2, 4'hE, 30'h48D);
    cs(32'h1231, 4, 0, 0, 0, 1, 3, 4'hE, 30'h48D);
    cs(32'h1231, 4, 0, 0, 0, 2, 4, 4'hE, 30'h48D);
    cs(32'h1233, 2, 0, 0, 0, 0, 2, 4'hE, 30'h48D);
    cs(32'h1231, 2, 0, 0, 0, 1, 2, 4'h9, 30'h48C);
    cs(32'h1232, 1, 0, 0, 0, 2, 1, 4'hB, 30'h48C);
    cs(32'h0001FFFC, 4, 0, 1, 0, 0, 1, 4'h0, 30'h3FFF);
    cs(32'h1231, 2, 1, 0, 0, 0, 1, 4'h9, 30'h48C);
    cs(32'h1230, 4, 1, 0, 0, 2, 4, 4'h0, 30'h48C);
    cs(32'h1234, 4, 0, 0, 1, 2, 16, 4'h0, 30'h48C);
    cs(32'h1234, 4, 0, 0, 1, 1, 8, 4'h0, 30'h48C);
    wid = 2'h0;
    t_fifo();
    print_verdict();
  end
endmodule // bldbs_bench

// ===== test/bldbs_checker.sv
// Concurrent checks on the bus sizing sequencer ports
`timescale 1ns/100ps
module bldbs_checker (
  input wire logic CLK_SYS, // Clock
  input wire logic ARST_N, // Reset, low
  input wire logic RSP_VALID, // Completion pulse
  input wire logic BUS_START, // Cycle start
  input wire logic [29:0] BUS_WORD_ADDR, // Word address
  input wire logic [3:0] BYTE_LANE_SEL_N, // Selects, low
  input wire logic BUS_MEM, // Memory cycle
  input wire logic BUS_WRITE, // Write cycle
  input wire logic BUS_READY_N, // Cycle end, low
  input wire logic HALF_WIDTH_REQ_N, // Half width, low
  input wire logic BYTE_WIDTH_REQ_N, // Byte width, low
  input wire logic [31:0] DATA_LANES_O, // Lanes out
  input wire logic DATA_LANES_OE_N // Lane drive, low
);
  logic out_q, out_d, end_q, end_d, outst, w8;
  logic [3:0] act, exp_q, exp_d;
  logic [29:0] word_q, word_d;
  logic [31:0] mask;
  //----------------------------------------------------------------
  // Cycle tracking
  //----------------------------------------------------------------
  // A cycle is open from its start pulse until ready is seen low
  always_comb begin
    act = ~BYTE_LANE_SEL_N;
    outst = BUS_START | out_q;
    out_d = outst & BUS_READY_N;
    end_d = outst & !BUS_READY_N;
    w8 = !BYTE_WIDTH_REQ_N;
    exp_d = exp_q;
    word_d = word_q;
    mask = {{8{act[3]}}, {8{act[2]}}, {8{act[1]}}, {8{act[0]}}};
    if (end_d) begin
      exp_d = w8 ? (BYTE_LANE_SEL_N | (act & (~act + 4'h1)))
                 : {BYTE_LANE_SEL_N[3:2], 2'h3};
      word_d = BUS_WORD_ADDR;
    end
  end
  // Only registers the tracking state
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      out_q <= 1'b0;
      end_q <= 1'b0;
      exp_q <= 4'hF;
      word_q <= 30'h0;
    end else begin
      out_q <= out_d;
      end_q <= end_d;
      exp_q <= exp_d;
      word_q <= word_d;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  sequence s_end;
    outst && !BUS_READY_N;
  endsequence
  // Extra cycle may take a few edges to issue, never more than four
  sequence s_next;
    ##[1:4] BUS_START && BYTE_LANE_SEL_N == exp_q && BUS_WORD_ADDR == word_q;
  endsequence
  property p_gap;
    !(BYTE_LANE_SEL_N inside {4'h2, 4'h4, 4'h5, 4'h6, 4'hA});
  endproperty
  a_gap: assert property (p_gap) else $error("gap in selects");
  property p_start;
    BUS_START |-> BYTE_LANE_SEL_N != 4'hF;
  endproperty
  a_start: assert property (p_start) else $error("no lane");
  property p_hold;
    outst && BUS_READY_N |=> $stable(BYTE_LANE_SEL_N) && $stable(BUS_WORD_ADDR);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_byte_next;
    s_end ##0 (w8 && (act & (act - 4'h1)) != 4'h0) |-> s_next;
  endproperty
  a_byte_next: assert property (p_byte_next) else $error("byte step");
  property p_half_next;
    s_end ##0 (!w8 && !HALF_WIDTH_REQ_N && act[1:0] != 2'h0
      && act[3:2] != 2'h0) |-> s_next;
  endproperty
  a_half_next: assert property (p_half_next) else $error("half step");
  property p_rsp;
    RSP_VALID |-> end_q;
  endproperty
  a_rsp: assert property (p_rsp) else $error("early response");
  property p_io;
    BUS_START && !BUS_MEM |-> BUS_WORD_ADDR[29:14] == 16'h0;
  endproperty
  a_io: assert property (p_io) else $error("io range");
  property p_lanes;
    !DATA_LANES_OE_N |-> BUS_WRITE && (DATA_LANES_O & ~mask) == 32'h0;
  endproperty
  a_lanes: assert property (p_lanes) else $error("stray lane");
endmodule // bldbs_checker

bind bldbs_top bldbs_checker u_chk (
  .CLK_SYS(CLK_SYS),
  .ARST_N(ARST_N),
  .RSP_VALID(RSP_VALID),
  .BUS_START(BUS_START),
  .BUS_WORD_ADDR(BUS_WORD_ADDR),
  .BYTE_LANE_SEL_N(BYTE_LANE_SEL_N),
  .BUS_MEM(BUS_MEM),
  .BUS_WRITE(BUS_WRITE),
  .BUS_READY_N(BUS_READY_N),
  .HALF_WIDTH_REQ_N(HALF_WIDTH_REQ_N),
  .BYTE_WIDTH_REQ_N(BYTE_WIDTH_REQ_N),
  .DATA_LANES_O(DATA_LANES_O),
  .DATA_LANES_OE_N(DATA_LANES_OE_N)
);

// ===== test/bldbs_dev.sv
// Far-side device model: width decode, ready timing, read lanes
`timescale 1ns/100ps
module bldbs_dev (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, low
  input wire logic bus_start, // Cycle start
  input wire logic [29:0] word_addr, // Word address
  input wire logic [3:0] sel_n, // Selects, low
  input wire logic [1:0] wid, // 0:32 1:16 2:8 3:both
  input wire logic [4:0] dly, // Wait cycles before ready
  output logic ready_n, // Cycle end, low
  output logic half_n, // Half width, low
  output logic byte_n, // Byte width, low
  output logic [31:0] lanes // Read lanes
);
  logic busy_q;
  logic [4:0] cnt_q;
  logic [1:0] lo2;
  logic hw_bit, ble_n, bhe_n;
  logic [3:0] live;
  //----------------------------------------------------------------
  // Device behaviour
  //----------------------------------------------------------------
  // Decoder holds its width for the whole access, extras included
  assign half_n = !wid[0];
  assign byte_n = !wid[1];
  // Narrow devices decode the selects into their own address bits;
  // only the lanes that decode names are really driven
  always_comb begin
    lo2 = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (!sel_n[k]) begin
        lo2 = 2'(k);
      end
    end
    hw_bit = &sel_n[1:0];
    ble_n = lo2[0];
    bhe_n = hw_bit ? sel_n[3] : sel_n[1];
    for (int k = 0; k < 4; k++) begin
      if (wid[1]) begin
        live[k] = 2'(k) == lo2;
      end else if (wid[0]) begin
        live[k] = (k / 2 == int'(hw_bit))
                  && ((k % 2 == 1) ? !bhe_n : !ble_n);
      end else begin
        live[k] = !sel_n[k];
      end
    end
  end
  // Lanes toggle outside ready so a stale value never passes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h0;
      ready_n <= 1'b1;
      lanes <= 32'h0;
    end else begin
      ready_n <= 1'b1;
      lanes <= ~lanes;
      if (bus_start) begin
        busy_q <= 1'b1;
        cnt_q <= dly;
      end else if (busy_q && cnt_q != 5'h0) begin
        cnt_q <= cnt_q - 5'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        ready_n <= 1'b0;
        for (int k = 0; k < 4; k++) begin
          lanes[8*k +: 8] <= {word_addr[5:0], 2'(k)} ^ {8{!live[k]}}
                             ^ 8'hA5;
        end
      end
    end
  end
endmodule // bldbs_dev
